/* File: zfd_defs.vh */
// Purpose: shared constants of the zero and full-scale detector
// Assumes: included once per design file by its bare name
// Notes: register offsets are word indices, byte address is four times the index
`ifndef ZFD_DEFS_VH
`define ZFD_DEFS_VH
// ----------------------------------------
// register indices
// ----------------------------------------
`define ZFD_IDX_POLARITY 4'h2
`define ZFD_IDX_SOURCE 4'h6
`define ZFD_IDX_LEFT_MON 4'h7
`define ZFD_IDX_RIGHT_MON 4'h8
`define ZFD_IDX_MODE 4'h9
`define ZFD_IDX_STATUS 4'hA
// ----------------------------------------
// field positions
// ----------------------------------------
`define ZFD_POL_BIT 2
`define ZFD_SRC_BIT 4
`define ZFD_MON_LSB 4
`define ZFD_MODE_SOFT_RESET_N 0
`define ZFD_MODE_FSMUTE 1
`define ZFD_MODE_TSEL 2
`define ZFD_MODE_BYPASS 3
`define ZFD_MODE_DSD 4
`define ZFD_MODE_OCTHEX 5
`define ZFD_MODE_RAMP_LSB 6
`define ZFD_MODE_PWR_LSB 8
// ----------------------------------------
// reset values
// ----------------------------------------
`define ZFD_RST_BYTE 8'h00
`define ZFD_RST_MODE 12'h000
// ----------------------------------------
// timing counts
// ----------------------------------------
`define ZFD_ZERO_NORMAL 17'h02000
`define ZFD_ZERO_OCTHEX 17'h10000
`define ZFD_ZERO_DSD 17'h01000
`define ZFD_RST_RELEASE 3'h3
`define ZFD_FS_LONG 9'h100
`define ZFD_FS_SHORT 9'h080
`define ZFD_DELAY_EXTRA 9'h008
`define ZFD_RAMP_STEP_00 5'h10
`define ZFD_RAMP_STEP_01 5'h08
`define ZFD_RAMP_STEP_10 5'h02
`define ZFD_RAMP_STEP_11 5'h01
`endif

/* File: zfd_sync.v */
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: the first stage feeds only the second
// Notes: clock enable low freezes both stages
`timescale 1ns/1ps
module zfd_sync #(
   parameter W = 1
) (
   // clock
   input wire aclk,
   input wire aresetn,
   input wire aclk_en,
   // data
   input wire [W-1:0] async_in,
   output reg [W-1:0] sync_out
);
   reg [W-1:0] meta_reg;
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else if (aclk_en) begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule // zfd_sync

/* File: zfd_delay_mem.v */
// Purpose: circular memory holding the eight-channel bit stream
// Assumes: one write per bit-clock edge, read address set by the caller
// Notes: read data comes out of a register, one clock after the address
`timescale 1ns/1ps
module zfd_delay_mem (
   // clock
   input wire aclk,
   input wire aclk_en,
   // write side
   input wire wr_en,
   input wire [8:0] wr_addr,
   input wire [7:0] wr_data,
   // read side
   input wire [8:0] rd_addr,
   output reg [7:0] rd_data
);
   reg [7:0] mem [0:511];
   always @(posedge aclk) begin
      if (aclk_en) begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data <= mem[rd_addr];
      end
   end
endmodule // zfd_delay_mem

/* File: zfd_top.v */
// Purpose: zero-data and bit-stream full-scale detection with flag pin and mute
// Assumes: sample_tick is one aclk pulse per sample period from local logic;
//          bit clock and stream inputs are asynchronous pins
`timescale 1ns/1ps
`include "zfd_defs.vh"
module zfd_top (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   input wire aclk_en,
   // register bus
   input wire [5:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [5:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // sample path, local logic
   input wire sample_tick,
   input wire [7:0] att_out_zero,
   // stream pins, left 1-4 in 3:0, right 1-4 in 7:4
   input wire dsd_bit_clock,
   input wire [3:0] left_dsd_inputs,
   input wire [3:0] right_dsd_inputs,
   // outputs
   output reg detect_flag_pin,
   output reg [7:0] dsd_out,
   output reg dsd_out_valid,
   output reg [7:0] mute_level,
   output reg internal_reset_n
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function is_onehot;
      input [7:0] v;
      integer k;
      reg [3:0] n;
      begin
         n = 4'h0;
         for (k = 0; k < 8; k = k + 1) begin
            n = n + {3'h0, v[k]};
         end
         is_onehot = (n == 4'h1);
      end
   endfunction

   function [9:0] reg_index_ok;
      input [5:0] addr;
      begin
         reg_index_ok = {addr[1:0] == 2'b00, 1'b0, 4'h0, addr[5:2]};
      end
   endfunction

   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [7:0] polarity_reg;
   reg [7:0] source_reg;
   reg [7:0] left_mon_reg;
   reg [7:0] right_mon_reg;
   reg [11:0] mode_reg;
   wire [7:0] fs_flag_reg;
   reg zero_flag_reg;
   reg mute_reg;

   wire flag_polarity_invert = polarity_reg[`ZFD_POL_BIT];
   wire flag_source_select = source_reg[`ZFD_SRC_BIT];
   wire [3:0] left_monitor_bits = left_mon_reg[`ZFD_MON_LSB+3:`ZFD_MON_LSB];
   wire [3:0] right_monitor_bits = right_mon_reg[`ZFD_MON_LSB+3:`ZFD_MON_LSB];
   wire [7:0] monitor_sel = {right_monitor_bits, left_monitor_bits};
   wire soft_reset_n = mode_reg[`ZFD_MODE_SOFT_RESET_N];
   wire fullscale_mute_enable = mode_reg[`ZFD_MODE_FSMUTE];
   wire fullscale_time_select = mode_reg[`ZFD_MODE_TSEL];
   wire dsd_volume_bypass = mode_reg[`ZFD_MODE_BYPASS];
   wire dsd_mode = mode_reg[`ZFD_MODE_DSD];
   wire oct_hex_mode = mode_reg[`ZFD_MODE_OCTHEX];
   wire [1:0] ramp_rate_field = mode_reg[`ZFD_MODE_RAMP_LSB+1:`ZFD_MODE_RAMP_LSB];
   wire [3:0] pair_power_on = mode_reg[`ZFD_MODE_PWR_LSB+3:`ZFD_MODE_PWR_LSB];
   wire [7:0] chan_power = {pair_power_on, pair_power_on};

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   // address and data are taken together, so either arrival order works
   wire wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
   wire rd_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
   wire [9:0] wdec = reg_index_ok(s_axi_awaddr);
   wire [9:0] rdec = reg_index_ok(s_axi_araddr);
   wire [3:0] widx = wdec[3:0];
   wire [3:0] ridx = rdec[3:0];
   wire w_mapped = wdec[9] && (widx == `ZFD_IDX_POLARITY || widx == `ZFD_IDX_SOURCE ||
                   widx == `ZFD_IDX_LEFT_MON || widx == `ZFD_IDX_RIGHT_MON ||
                   widx == `ZFD_IDX_MODE || widx == `ZFD_IDX_STATUS);
   reg [31:0] rd_mux;
   reg r_mapped;

   always @* begin
      rd_mux = 32'h00000000;
      r_mapped = rdec[9];
      case (ridx)
         `ZFD_IDX_POLARITY: rd_mux = {24'h000000, polarity_reg};
         `ZFD_IDX_SOURCE: rd_mux = {24'h000000, source_reg};
         `ZFD_IDX_LEFT_MON: rd_mux = {24'h000000, left_mon_reg};
         `ZFD_IDX_RIGHT_MON: rd_mux = {24'h000000, right_mon_reg};
         `ZFD_IDX_MODE: rd_mux = {20'h00000, mode_reg};
         `ZFD_IDX_STATUS: rd_mux = {22'h000000, mute_reg, zero_flag_reg, fs_flag_reg};
         default: r_mapped = 1'b0;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'b00;
         s_axi_rdata <= 32'h00000000;
         polarity_reg <= `ZFD_RST_BYTE;
         source_reg <= `ZFD_RST_BYTE;
         left_mon_reg <= `ZFD_RST_BYTE;
         right_mon_reg <= `ZFD_RST_BYTE;
         mode_reg <= `ZFD_RST_MODE;
      end else if (aclk_en) begin
         s_axi_awready <= wr_take;
         s_axi_wready <= wr_take;
         s_axi_arready <= rd_take;
         if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= w_mapped ? 2'b00 : 2'b10;
            if (w_mapped && s_axi_wstrb[0]) begin
               case (widx)
                  `ZFD_IDX_POLARITY: polarity_reg <= s_axi_wdata[7:0];
                  `ZFD_IDX_SOURCE: source_reg <= s_axi_wdata[7:0];
                  `ZFD_IDX_LEFT_MON: left_mon_reg <= s_axi_wdata[7:0];
                  `ZFD_IDX_RIGHT_MON: right_mon_reg <= s_axi_wdata[7:0];
                  `ZFD_IDX_MODE: mode_reg[7:0] <= s_axi_wdata[7:0];
                  default: mode_reg <= mode_reg;
               endcase
            end
            if (w_mapped && s_axi_wstrb[1] && widx == `ZFD_IDX_MODE) begin
               mode_reg[11:8] <= s_axi_wdata[11:8];
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= r_mapped ? 2'b00 : 2'b10;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // soft reset and zero detection
   // ----------------------------------------
   reg [2:0] rel_cnt_reg;
   reg [16:0] zero_cnt_reg;
   wire [16:0] zero_limit = dsd_mode ? `ZFD_ZERO_DSD :
                            (oct_hex_mode ? `ZFD_ZERO_OCTHEX : `ZFD_ZERO_NORMAL);
   // standby channels report zero like any other, so no shortcut here
   wire sel_all_zero = ((att_out_zero & monitor_sel) == monitor_sel);

   always @(posedge aclk) begin
      if (!aresetn) begin
         rel_cnt_reg <= 3'h0;
         internal_reset_n <= 1'b0;
         zero_cnt_reg <= 17'h00000;
         zero_flag_reg <= 1'b1;
      end else if (aclk_en) begin
         if (!soft_reset_n) begin
            rel_cnt_reg <= 3'h0;
            internal_reset_n <= 1'b0;
            zero_cnt_reg <= 17'h00000;
            zero_flag_reg <= 1'b1;
         end else if (!internal_reset_n) begin
            if (sample_tick) begin
               rel_cnt_reg <= rel_cnt_reg + 3'h1;
               if (rel_cnt_reg + 3'h1 == `ZFD_RST_RELEASE) begin
                  internal_reset_n <= 1'b1;
               end
            end
         end else if (dsd_mode && dsd_volume_bypass) begin
            zero_cnt_reg <= 17'h00000;
            zero_flag_reg <= 1'b1;
         end else if (!sel_all_zero) begin
            zero_cnt_reg <= 17'h00000;
            zero_flag_reg <= 1'b0;
         end else if (sample_tick) begin
            // first tick after release clears the reset-forced flag
            if (zero_cnt_reg + 17'h00001 >= zero_limit) begin
               zero_flag_reg <= 1'b1;
            end else begin
               zero_cnt_reg <= zero_cnt_reg + 17'h00001;
               zero_flag_reg <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // stream input sampling
   // ----------------------------------------
   wire bclk_sync;
   wire [7:0] dsd_sync;
   reg bclk_prev_reg;
   zfd_sync #(.W(9)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .aclk_en(aclk_en),
      .async_in({dsd_bit_clock, right_dsd_inputs, left_dsd_inputs}),
      .sync_out({bclk_sync, dsd_sync})
   );
   wire bit_edge = bclk_sync && !bclk_prev_reg;
   wire [8:0] fs_limit = fullscale_time_select ? `ZFD_FS_SHORT : `ZFD_FS_LONG;
   wire fs_run = dsd_mode && internal_reset_n;

   // ----------------------------------------
   // per-channel full-scale detectors
   // ----------------------------------------
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_chan
         reg last_bit_reg;
         reg [8:0] run_cnt_reg;
         reg flag_reg;
         // one process owns each flag bit, the vector is only a bundle of them
         assign fs_flag_reg[g] = flag_reg;
         always @(posedge aclk) begin
            if (!aresetn) begin
               last_bit_reg <= 1'b0;
               run_cnt_reg <= 9'h000;
               flag_reg <= 1'b0;
            end else if (aclk_en) begin
               if (!fs_run || !chan_power[g]) begin
                  run_cnt_reg <= 9'h000;
                  flag_reg <= 1'b0;
               end else if (bit_edge) begin
                  last_bit_reg <= dsd_sync[g];
                  if (dsd_sync[g] != last_bit_reg) begin
                     run_cnt_reg <= 9'h001;
                     flag_reg <= 1'b0;
                  end else if (run_cnt_reg + 9'h001 >= fs_limit) begin
                     run_cnt_reg <= fs_limit;
                     flag_reg <= 1'b1;
                  end else begin
                     run_cnt_reg <= run_cnt_reg + 9'h001;
                  end
               end
            end
         end
      end
   endgenerate

   // ----------------------------------------
   // delay line
   // ----------------------------------------
   reg [8:0] wr_ptr_reg;
   reg bypass_valid_reg;
   wire [7:0] mem_rd;
   wire [8:0] delay_len = fs_limit + `ZFD_DELAY_EXTRA;
   zfd_delay_mem u_mem (
      .aclk(aclk),
      .aclk_en(aclk_en),
      .wr_en(bit_edge),
      .wr_addr(wr_ptr_reg),
      .wr_data(dsd_sync),
      .rd_addr(wr_ptr_reg - delay_len),
      .rd_data(mem_rd)
   );

   always @(posedge aclk) begin
      if (!aresetn) begin
         bclk_prev_reg <= 1'b0;
         wr_ptr_reg <= 9'h000;
         bypass_valid_reg <= 1'b0;
         dsd_out <= 8'h00;
         dsd_out_valid <= 1'b0;
      end else if (aclk_en) begin
         bclk_prev_reg <= bclk_sync;
         bypass_valid_reg <= bit_edge;
         if (bit_edge) begin
            wr_ptr_reg <= wr_ptr_reg + 9'h001;
         end
         dsd_out_valid <= bypass_valid_reg;
         if (bypass_valid_reg) begin
            // the delay only costs latency when the mute needs the lead time
            dsd_out <= fullscale_mute_enable ? mem_rd : dsd_sync;
         end
      end
   end

   // ----------------------------------------
   // mute and release ramp
   // ----------------------------------------
   localparam ST_RUN = 2'b00;
   localparam ST_MUTED = 2'b01;
   localparam ST_HOLD = 2'b10;
   localparam ST_RAMP = 2'b11;
   reg [1:0] mute_state_reg;
   reg [8:0] hold_cnt_reg;
   reg [4:0] step_cnt_reg;
   reg [4:0] step_len;
   // mute enable is assumed steady while pairs are powered or reset is low
   wire any_fs = fullscale_mute_enable && (|fs_flag_reg);

   always @* begin
      case (ramp_rate_field)
         2'b00: step_len = `ZFD_RAMP_STEP_00;
         2'b01: step_len = `ZFD_RAMP_STEP_01;
         2'b10: step_len = `ZFD_RAMP_STEP_10;
         default: step_len = `ZFD_RAMP_STEP_11;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         mute_state_reg <= ST_RUN;
         hold_cnt_reg <= 9'h000;
         step_cnt_reg <= 5'h00;
         mute_level <= 8'hFF;
         mute_reg <= 1'b0;
      end else if (aclk_en) begin
         if (any_fs) begin
            mute_state_reg <= ST_MUTED;
            mute_level <= 8'h00;
            mute_reg <= 1'b1;
            hold_cnt_reg <= 9'h000;
         end else begin
            case (mute_state_reg)
               ST_MUTED: begin
                  mute_state_reg <= ST_HOLD;
               end
               ST_HOLD: begin
                  if (hold_cnt_reg >= delay_len) begin
                     mute_reg <= 1'b0;
                     step_cnt_reg <= 5'h00;
                     if (dsd_volume_bypass) begin
                        mute_level <= 8'hFF;
                        mute_state_reg <= ST_RUN;
                     end else begin
                        mute_state_reg <= ST_RAMP;
                     end
                  end else if (bit_edge) begin
                     hold_cnt_reg <= hold_cnt_reg + 9'h001;
                  end
               end
               ST_RAMP: begin
                  if (mute_level == 8'hFF) begin
                     mute_state_reg <= ST_RUN;
                  end else if (sample_tick) begin
                     if (step_cnt_reg + 5'h01 >= step_len) begin
                        step_cnt_reg <= 5'h00;
                        mute_level <= mute_level + 8'h01;
                     end else begin
                        step_cnt_reg <= step_cnt_reg + 5'h01;
                     end
                  end
               end
               default: begin
                  mute_state_reg <= ST_RUN;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // flag pin
   // ----------------------------------------
   reg fs_pin_flag;
   integer i;
   always @* begin
      fs_pin_flag = |(fs_flag_reg & chan_power);
      if (is_onehot(monitor_sel)) begin
         fs_pin_flag = 1'b0;
         for (i = 0; i < 8; i = i + 1) begin
            if (monitor_sel[i]) begin
               fs_pin_flag = fs_flag_reg[i];
            end
         end
      end
   end

   // pcm mode with full-scale source reads as no detection
   wire pin_active = flag_source_select ? (dsd_mode && fs_pin_flag) : zero_flag_reg;

   always @(posedge aclk) begin
      if (!aresetn) begin
         detect_flag_pin <= 1'b0;
      end else if (aclk_en) begin
         detect_flag_pin <= pin_active ^ flag_polarity_invert;
      end
   end
endmodule // zfd_top

/* File: zfd_checker.sv */
// Purpose: port-level checks of the zero and full-scale detector
// Assumes: one clock domain, reset active low and synchronous
// Notes: bit clock period of at least four aclk cycles is taken as given
`timescale 1ns/1ps
module zfd_checker (
   // clock
   input wire aclk,
   input wire aresetn,
   input wire aclk_en,
   // register bus
   input wire s_axi_awvalid,
   input wire s_axi_wvalid,
   input wire s_axi_awready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   // datapath
   input wire sample_tick,
   input wire [7:0] dsd_out,
   input wire dsd_out_valid,
   input wire [7:0] mute_level,
   input wire internal_reset_n
);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [15:0] mz_cnt;
   // length of the current muted run, saturating so it never wraps to a false short run
   always @(posedge aclk) begin
      if (!aresetn || mute_level != 8'h00) mz_cnt <= 16'h0000;
      else if (mz_cnt != 16'hFFFF) mz_cnt <= mz_cnt + 16'h0001;
   end
   property p_wr_ans;
      aclk_en && s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid |=> s_axi_bvalid && s_axi_awready;
   endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write not answered next cycle");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
   property p_rd_ans;
      aclk_en && s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_axi_rvalid ##1 !s_axi_arready;
   endproperty
   a_rd_ans: assert property (p_rd_ans) else $error("read not answered next cycle");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
   property p_ramp;
      (mute_level > $past(mute_level)) && (mute_level != 8'hFF) |-> mute_level == $past(mute_level) + 8'h01;
   endproperty
   a_ramp: assert property (p_ramp) else $error("ramp step not one code");
   property p_onset;
      mute_level < $past(mute_level) |-> mute_level == 8'h00;
   endproperty
   a_onset: assert property (p_onset) else $error("mute onset not immediate");
   property p_rst_rel;
      $rose(internal_reset_n) |-> $past(sample_tick);
   endproperty
   a_rst_rel: assert property (p_rst_rel) else $error("internal reset released off a sample tick");
   property p_bit_pulse;
      dsd_out_valid |=> !dsd_out_valid;
   endproperty
   a_bit_pulse: assert property (p_bit_pulse) else $error("stream valid longer than one cycle");
   property p_bit_only;
      dsd_out != $past(dsd_out) |-> dsd_out_valid;
   endproperty
   a_bit_only: assert property (p_bit_only) else $error("stream out changed without valid");
   property p_hold_mute;
      $past(mute_level) == 8'h00 && mute_level != 8'h00 |-> $past(mz_cnt) > 16'h021C;
   endproperty
   a_hold_mute: assert property (p_hold_mute) else $error("mute released before register delay");
endmodule // zfd_checker

/* File: zfd_dsd_src.sv */
// Purpose: stream source feeding bit clock and eight channel pins
// Assumes: bit period 125 ns, data changes on the falling edge
// Notes: clock stands still while run is low
`timescale 1ns/1ps
module zfd_dsd_src (
   // control
   input wire run,
   input wire [7:0] hold,
   input wire [7:0] lvl,
   // pins
   output logic bclk,
   output logic [3:0] left_o,
   output logic [3:0] right_o
);
   logic [7:0] d;
   assign {right_o, left_o} = d;
   // held channels sit at lvl, the rest toggle every bit
   initial begin
      bclk = 1'b0;
      d = 8'h00;
      forever begin
         if (run) begin
            #62.5 bclk = 1'b1;
            #62.5 bclk = 1'b0;
            d = ((d ^ 8'hFF) & ~hold) | (lvl & hold);
         end else #5;
      end
   end
endmodule // zfd_dsd_src

/* File: tb_top.sv */
// Purpose: self-checking bench of the zero and full-scale detector
// Assumes: sample_tick pulses every cycle to shorten the sample counts
// Notes: one bit clock period is 25 aclk cycles
`timescale 1ns/1ps
`include "zfd_defs.vh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   logic aclk, aresetn, aclk_en, sample_tick, run, dsd_bit_clock, detect_flag_pin, dsd_out_valid, internal_reset_n;
   logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
   logic [3:0] s_axi_wstrb, left_dsd_inputs, right_dsd_inputs;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_r, wr_r;
   logic [7:0] att_out_zero, dsd_out, mute_level, hold, lvl;
   int bad_count, checked;
   zfd_top dut (.*);
   zfd_dsd_src src (.run(run), .hold(hold), .lvl(lvl), .bclk(dsd_bit_clock), .left_o(left_dsd_inputs),
      .right_o(right_dsd_inputs));
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // ----------------------------------------
   // bus and wait tasks
   // ----------------------------------------
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [3:0] i, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      wr_r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      // one more edge so that registered outputs already show the write
      @(posedge aclk);
   endtask
   task automatic rd(input logic [3:0] i);
      @(posedge aclk);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      rd_d = s_axi_rdata;
      rd_r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic wt_pin(input logic v, input int n);
      while (detect_flag_pin !== v && n > 0) begin
         @(posedge aclk);
         n--;
      end
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      logic [3:0] idx [5] = '{4'h2, 4'h6, 4'h7, 4'h8, 4'h9};
      foreach (idx[k]) begin
         rd(idx[k]);
         `CHK(rd_d, 32'h00000000)
      end
      rd(4'hF);
      `CHK({rd_r, rd_d}, {2'b10, 32'h00000000})
      wr(4'hF, 32'h000000FF);
      `CHK(wr_r, 2'b10)
      wr(4'h2, 32'hFFFFFFFF);
      rd(4'h2);
      `CHK(rd_d, 32'h000000FF)
      wr(4'h2, 32'h00000000);
   endtask
   task automatic t_zero();
      `CHK({detect_flag_pin, internal_reset_n}, 2'b10)
      wr(4'h7, 32'hF0);
      wr(4'h8, 32'hF0);
      att_out_zero <= 8'h00;
      wr(4'h9, 32'h001);
      cyc(8);
      `CHK({detect_flag_pin, internal_reset_n}, 2'b01)
      att_out_zero <= 8'hFF;
      cyc(8150);
      `CHK(detect_flag_pin, 1'b0)
      wt_pin(1'b1, 100);
      `CHK(detect_flag_pin, 1'b1)
      att_out_zero <= 8'h20;
      cyc(3);
      `CHK(detect_flag_pin, 1'b0)
      att_out_zero <= 8'hFF;
      cyc(4000);
      att_out_zero <= 8'hFE;
      cyc(1);
      att_out_zero <= 8'hFF;
      cyc(5000);
      `CHK(detect_flag_pin, 1'b0)
      wt_pin(1'b1, 3400);
      `CHK(detect_flag_pin, 1'b1)
      wr(4'h7, 32'h10);
      wr(4'h8, 32'h00);
      att_out_zero <= 8'hFD;
      wr(4'h2, 32'h04);
      `CHK(detect_flag_pin, 1'b0)
      wr(4'h6, 32'h10);
      `CHK(detect_flag_pin, 1'b1)
      wr(4'h2, 32'h00);
      `CHK(detect_flag_pin, 1'b0)
      wr(4'h6, 32'h00);
      `CHK(detect_flag_pin, 1'b1)
      att_out_zero <= 8'hFE;
      cyc(3);
      `CHK(detect_flag_pin, 1'b0)
      wr(4'h9, 32'h019);
      cyc(4);
      `CHK(detect_flag_pin, 1'b1)
   endtask
   task automatic t_fs();
      hold <= 8'h01;
      run <= 1'b1;
      wr(4'h9, 32'hFD6);
      wr(4'h6, 32'h10);
      wr(4'h9, 32'hFD7);
      cyc(2500);
      rd(4'hA);
      `CHK(rd_d[7:0], 8'h00)
      cyc(1500);
      rd(4'hA);
      `CHK(rd_d[7:0], 8'h01)
      `CHK({detect_flag_pin, mute_level}, 9'h100)
      wr(4'h7, 32'h30);
      `CHK(detect_flag_pin, 1'b1)
      wr(4'h7, 32'h20);
      `CHK(detect_flag_pin, 1'b0)
      hold <= 8'h00;
      cyc(250);
      rd(4'hA);
      `CHK(rd_d[7:0], 8'h00)
      `CHK(dsd_out[0], 1'b1)
      cyc(25);
      `CHK(dsd_out[0], 1'b1)
      cyc(2500);
      `CHK(mute_level, 8'h00)
      cyc(2500);
      `CHK(mute_level, 8'hFF)
      hold <= 8'h01;
      cyc(4000);
      wr(4'h9, 32'h0D7);
      rd(4'hA);
      `CHK(rd_d[7:0], 8'h00)
      wr(4'h9, 32'h01F);
      cyc(3600);
      `CHK(mute_level, 8'hFF)
   endtask
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task automatic summarize();
      $display("compares %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, run} = 7'h00;
      {aclk_en, sample_tick, s_axi_wstrb, hold, lvl, att_out_zero} = {2'b11, 4'hF, 8'h00, 8'h01, 8'hFF};
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
      bad_count = 0;
      checked = 0;
      cyc(16);
      aresetn <= 1'b1;
      cyc(2);
      t_regs();
      t_zero();
      t_fs();
      summarize();
   end
   // tests need about 40k cycles, so 400 us leaves ample margin
   initial begin
      #400000;
      bad_count++;
      summarize();
   end
endmodule // tb_top
bind zfd_top zfd_checker chk (.*);
